// ==== bench/pfc_link_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Link partner: sinks TX bytes, sends RX frames.
// ----------------------------------------
module pfc_link_model (
    input  wire logic       pclk,
    input  wire logic [7:0] link_tx_data,
    input  wire logic       link_tx_valid,
    input  wire logic       link_tx_last,
    output logic            link_tx_ready,
    output logic      [7:0] link_rx_data,
    output logic            link_rx_valid,
    output logic            link_rx_last,
    input  wire logic       rx_pause_seen,
    input  wire logic       stall,
    input  wire logic       slow
);
    logic [7:0] got[$];
    int         n_frames = 0, n_seen = 0;
    // Idle levels at time zero.
    initial
    begin
        link_tx_ready = 1'b0;
        link_rx_data  = 8'h00;
        link_rx_valid = 1'b0;
        link_rx_last  = 1'b0;
    end
    // Ready falls every other cycle when slow, so held bytes get exercised.
    always @(posedge pclk)
    begin
        link_tx_ready <= !stall && !(slow && link_tx_ready);
        if (link_tx_valid && link_tx_ready)
        begin
            got.push_back(link_tx_data);
            n_frames = n_frames + int'(link_tx_last);
        end
        n_seen = n_seen + int'(rx_pause_seen);
    end
    // One 60-byte control frame; idle data is the inverse of the last byte so it is never stale.
    task automatic send_rx(input logic [47:0] da, input logic [15:0] op);
        logic [159:0] hdr;
        logic [7:0]   b;
        hdr = {da, 48'h0, pfc_pkg::ETYPE_CTRL, op, 16'h0002, 16'h0}; // Quanta of two.
        for (int i = 0; i < 60; i++)
        begin
            b = (i < 20) ? hdr[159-8*i -: 8] : 8'h00;
            @(posedge pclk);
            link_rx_data  <= b;
            link_rx_valid <= 1'b1;
            link_rx_last  <= (i == 59);
        end
        @(posedge pclk);
        link_rx_valid <= 1'b0;
        link_rx_last  <= 1'b0;
        link_rx_data  <= ~b;
    endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Top bench: APB, client, link and pause traffic.
// ----------------------------------------
module tb_top;
    localparam logic [47:0] SA = 48'h112233445566;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pause_req = 1'b0, cl_tx_valid = 1'b0, cl_tx_last = 1'b0;
    logic        stall = 1'b0, slow = 1'b0, er;
    logic [7:0]  paddr = 8'h00, cl_tx_data = 8'h00, link_tx_data, link_rx_data;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, cl_tx_ready, link_tx_valid, link_tx_last, link_tx_ready;
    logic        link_rx_valid, link_rx_last, rx_pause_seen;
    int          n_mismatch = 0, n_compared = 0, cyc = 0;

    pfc_top #(.PFC_EN(1'b0)) dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .pause_req, .cl_tx_data, .cl_tx_valid,
        .cl_tx_last, .cl_tx_ready, .link_tx_data, .link_tx_valid, .link_tx_last,
        .link_tx_ready, .link_rx_data, .link_rx_valid, .link_rx_last, .rx_pause_seen);
    pfc_link_model link_u (.pclk, .link_tx_data, .link_tx_valid, .link_tx_last,
        .link_tx_ready, .link_rx_data, .link_rx_valid, .link_rx_last, .rx_pause_seen,
        .stall, .slow);

    always #20 pclk = ~pclk;
    // The ceiling is several times the expected run, so only a hang reaches it.
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_mismatch++;
            $display("MISMATCH %0t timeout", $time);
            final_report();
        end
    end

    task automatic check(input logic [47:0] s, input logic [47:0] e, input string m);
        n_compared++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s: %0h vs %0h", $time, m, s, e);
        end
    endtask

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen high at a rising edge.
    // Only the bench timeout ends the wait, so a slave that never answers is caught.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic r;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // The answer is taken at the very edge that shows pready high.
        do
        begin
            @(posedge pclk);
            r  = pready;
            rd = prdata;
            er = pslverr;
        end
        while (!r);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Offers one client byte; valid stays up so back-to-back bytes need no idle cycle.
    task automatic push(input logic [7:0] b, input logic l, input int lim, output logic r);
        int k;
        k = 0;
        cl_tx_data  <= b;
        cl_tx_valid <= 1'b1;
        cl_tx_last  <= l;
        // Ready is judged at the rising edge that takes the byte.
        do
        begin
            @(posedge pclk);
            r = cl_tx_ready;
            k++;
        end
        while (!r && k < lim);
    endtask

    task automatic wait_frames(input int t);
        for (int k = 0; k < 2000 && link_u.n_frames < t; k++)
            @(posedge pclk);
    endtask

    function automatic logic [7:0] cb(input int i);
        return (i < 12) ? 8'(8'h40 + i) : 8'(i);
    endfunction

    task automatic chk_pause(input logic [15:0] q);
        logic [159:0] h;
        h = {pfc_pkg::PAUSE_DA, SA, pfc_pkg::ETYPE_CTRL, pfc_pkg::OP_PAUSE, q, 16'h0};
        check(48'(link_u.got.size() >= 60), 48'h1, "frame size");
        for (int i = 0; i < 60; i++)
            check(48'(link_u.got.pop_front()), (i < 20) ? 48'(h[159-8*i -: 8]) : 48'h0,
                "pause byte"); // Frame built from registers.
    endtask

    // Pending XOFF repeats may still arrive before the XON.
    task automatic xon(input logic [15:0] q);
        for (int k = 0; k < 4; k++)
            if (link_u.got.size() < 60)
                wait_frames(link_u.n_frames + 1);
            else if ({link_u.got[16], link_u.got[17]} !== 16'h0)
                chk_pause(q);
        chk_pause(16'h0); // XON carries zero quanta.
    endtask

    task automatic rx(input logic [47:0] da, input logic [15:0] op, input int d);
        int n;
        n = link_u.n_seen;
        link_u.send_rx(da, op);
        repeat (4) @(posedge pclk);
        check(48'(link_u.n_seen - n), 48'(d), "pause seen");
    endtask

    task automatic t_regs();
        logic [7:0]  ra[7];
        logic [31:0] rv[7];
        ra = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
        rv = '{32'h7, 32'hFFFF, 32'h100, 32'hC2000001, 32'h180, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            check(48'(rd), 48'(rv[i]), "reset value");
        end
        apb(1'b0, 8'h20, 32'h0);
        check(48'({er, rd}), 48'h1_0000_0000, "unmapped");
        $display("test regs done");
    endtask

    task automatic t_client();
        int   f0, acc;
        logic ok;
        f0  = link_u.n_frames;
        acc = 0;
        ok  = 1'b1;
        stall <= 1'b1;
        while (ok && acc < 12)
        begin
            push(cb(acc), 1'b0, 2, ok);
            acc = acc + int'(ok);
        end
        check(48'(acc >= 8 && acc <= 9), 48'h1, "buffer refusal");
        stall <= 1'b0;
        slow  <= 1'b1;
        for (int i = acc; i < 60; i++)
            push(cb(i), i == 59, 500, ok);
        cl_tx_valid <= 1'b0;
        cl_tx_last  <= 1'b0;
        wait_frames(f0 + 1);
        for (int i = 0; i < 60; i++)
            check(48'(link_u.got.pop_front()), 48'(cb(i)), "client byte"); // Own SA kept.
        $display("test client done");
    endtask

    task automatic t_pause();
        apb(1'b1, pfc_pkg::ADDR_SA_LO, SA[31:0]);
        apb(1'b1, pfc_pkg::ADDR_SA_HI, {16'h0, SA[47:32]});
        apb(1'b1, pfc_pkg::ADDR_QUANTA, 32'h5);
        apb(1'b1, pfc_pkg::ADDR_HOLDOFF, 32'h4);
        pause_req <= 1'b1;
        wait_frames(link_u.n_frames + 2);
        chk_pause(16'h5); // XOFF on the rising request.
        chk_pause(16'h5); // Repeat after the hold-off.
        pause_req <= 1'b0;
        xon(16'h5);
        apb(1'b1, pfc_pkg::ADDR_QUANTA, 32'h0);
        apb(1'b1, pfc_pkg::ADDR_CTRL, 32'hF);
        wait_frames(link_u.n_frames + 1);
        chk_pause(16'h1); // Register request; zero quanta goes out as one.
        apb(1'b1, pfc_pkg::ADDR_CTRL, 32'h7);
        xon(16'h1);
        apb(1'b1, pfc_pkg::ADDR_CTRL, 32'h5);
        pause_req <= 1'b1;
        repeat (200) @(posedge pclk);
        check(48'(link_u.got.size()), 48'h0, "gated request");
        pause_req <= 1'b0;
        apb(1'b1, pfc_pkg::ADDR_CTRL, 32'h7);
        $display("test pause done");
    endtask

    task automatic t_rx();
        rx(pfc_pkg::FDA_RST, pfc_pkg::OP_PAUSE, 1); // Matching address accepted.
        apb(1'b0, pfc_pkg::ADDR_STATUS, 32'h0);
        check(48'(rd[23:0] & 24'hFFFF02), 48'h102, "timer");
        rx(pfc_pkg::FDA_RST ^ 48'h1, pfc_pkg::OP_PAUSE, 0); // Other address dropped.
        apb(1'b0, pfc_pkg::ADDR_STATUS, 32'h0);
        check(48'(rd[23:16]), 48'h1, "rejected");
        apb(1'b1, pfc_pkg::ADDR_CTRL, 32'h3);
        rx(pfc_pkg::FDA_RST, pfc_pkg::OP_PAUSE, 0); // Receive enable off.
        apb(1'b1, pfc_pkg::ADDR_CTRL, 32'h6);
        rx(pfc_pkg::FDA_RST, pfc_pkg::OP_PFC, 0); // Priority opcode not built in.
        rx(pfc_pkg::FDA_RST, pfc_pkg::OP_PAUSE, 1);
        apb(1'b0, pfc_pkg::ADDR_STATUS, 32'h0);
        check(48'(rd[1]), 48'h0, "no tx pause");
        $display("test rx done");
    endtask

    // Reset is held for sixteen cycles, then the tests run in turn.
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_client();
        t_pause();
        t_rx();
        final_report();
    end
endmodule

// ==== rtl/pfc_pkg.sv ====
package pfc_pkg;
    // ---------------------------------------------------------------
    // Register map, byte addresses on the APB bus.
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_QUANTA  = 8'h04;
    localparam logic [7:0] ADDR_HOLDOFF = 8'h08;
    localparam logic [7:0] ADDR_FDA_LO  = 8'h0C;
    localparam logic [7:0] ADDR_FDA_HI  = 8'h10;
    localparam logic [7:0] ADDR_SA_LO   = 8'h14;
    localparam logic [7:0] ADDR_SA_HI   = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h1C;
    // ---------------------------------------------------------------
    // Control field positions and values after reset.
    // ---------------------------------------------------------------
    localparam int         CTRL_TXRX_EN = 0;
    localparam int         CTRL_USER_EN = 1;
    localparam int         CTRL_RX_EN   = 2;
    localparam int         CTRL_REG_REQ = 3;
    localparam logic [3:0]  CTRL_RST     = 4'h7;
    localparam logic [15:0] QUANTA_RST   = 16'hFFFF;
    localparam logic [15:0] HOLDOFF_RST  = 16'h0100;
    localparam logic [47:0] FDA_RST      = 48'h0180C2000001;
    localparam logic [47:0] SA_RST       = 48'h000000000000;
    // ---------------------------------------------------------------
    // Control frame layout and timing.
    // ---------------------------------------------------------------
    localparam logic [47:0] PAUSE_DA     = 48'h0180C2000001;
    localparam logic [15:0] ETYPE_CTRL   = 16'h8808;
    localparam logic [15:0] OP_PAUSE     = 16'h0001;
    localparam logic [15:0] OP_PFC       = 16'h0101;
    localparam logic [5:0]  FRAME_LAST   = 6'h3B;
    localparam logic [4:0]  RX_HDR_LAST  = 5'h13;
    localparam int          QUANTA_SHIFT = 6;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          DATA_W       = 8;
    typedef enum logic [1:0] {TX_IDLE, TX_CLIENT, TX_PAUSE} pfc_tx_state_type;
endpackage

// ==== rtl/pfc_top.sv ====
`timescale 1ns/1ps
// -------------------------------------------------------------------
// Word FIFO with flip-flop storage.
// -------------------------------------------------------------------
module pfc_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0]         wp;
        logic [AW:0]         rp;
    } pfc_fifo_type;
    pfc_fifo_type r;
    pfc_fifo_type next_r;
    logic [AW:0]  count;

    // Full and empty come from the pointer distance.
    assign count     = r.wp - r.rp;
    assign in_ready  = count != (AW+1)'(D);
    assign out_valid = count != '0;
    assign out_data  = r.mem[r.rp[AW-1:0]];

    // Push and pop update the pointers.
    always_comb
    begin
        next_r = r;
        if (in_valid && in_ready)
        begin
            next_r.mem[r.wp[AW-1:0]] = in_data;
            next_r.wp = r.wp + 1'b1;
        end
        if (out_valid && out_ready)
            next_r.rp = r.rp + 1'b1;
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else
            r <= next_r;
    end
endmodule

module pfc_top #(
    parameter bit PFC_EN = 1'b0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pause_req,
    input  wire logic [7:0]  cl_tx_data,
    input  wire logic        cl_tx_valid,
    input  wire logic        cl_tx_last,
    output logic             cl_tx_ready,
    output logic      [7:0]  link_tx_data,
    output logic             link_tx_valid,
    output logic             link_tx_last,
    input  wire logic        link_tx_ready,
    input  wire logic [7:0]  link_rx_data,
    input  wire logic        link_rx_valid,
    input  wire logic        link_rx_last,
    output logic             rx_pause_seen
);
    typedef struct packed {
        pfc_pkg::pfc_tx_state_type st;
        logic [5:0]           pidx;
        logic                 pkind;
        logic                 pend_xoff;
        logic                 pend_xon;
        logic                 req_q;
        logic [15:0]          hold;
        logic [21:0]          rxp;
        logic [3:0]           ctrl;
        logic [15:0]          quanta;
        logic [15:0]          holdoff;
        logic [47:0]          fda;
        logic [47:0]          sa;
        logic [31:0]          prdata;
        logic [7:0]           odata;
        logic                 ovalid;
        logic                 olast;
        logic [4:0]           rx_idx;
        logic [19:0][7:0]     hdr;
        logic [7:0]           acc;
        logic [7:0]           rej;
        logic                 seen;
    } pfc_top_type;

    pfc_top_type r;
    pfc_top_type next_r;
    logic [8:0]  f_data;
    logic        f_valid;
    logic        f_pop;
    logic        adv;
    logic        req_eff;
    logic [15:0] q_eff;
    logic        rx_done;
    logic        is_pause;
    logic        da_match;

    // ---------------------------------------------------------------
    // Helpers.
    // ---------------------------------------------------------------
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a <= pfc_pkg::ADDR_STATUS);
    endfunction

    function automatic logic [15:0] hdr16(input logic [19:0][7:0] h, input int p);
        hdr16 = {h[p], h[p+1]};
    endfunction

    function automatic logic [7:0] pause_byte(
        input logic [5:0]  i,
        input logic [47:0] sa,
        input logic [15:0] q
    );
        logic [63:0] w;
        w = '0;
        if (i < 6'h06)
            w[7:0] = pfc_pkg::PAUSE_DA[8*(5-int'(i)) +: 8];
        else if (i < 6'h0C)
            w[7:0] = sa[8*(11-int'(i)) +: 8];
        else if (i < 6'h0E)
            w[7:0] = pfc_pkg::ETYPE_CTRL[8*(13-int'(i)) +: 8];
        else if (i < 6'h10)
            w[7:0] = pfc_pkg::OP_PAUSE[8*(15-int'(i)) +: 8];
        else if (i < 6'h12)
            w[7:0] = q[8*(17-int'(i)) +: 8];
        pause_byte = w[7:0];
    endfunction

    // ---------------------------------------------------------------
    // Client transmit buffer.
    // ---------------------------------------------------------------
    pfc_fifo #(.W(9), .D(pfc_pkg::FIFO_DEPTH)) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_data   ({cl_tx_last, cl_tx_data}),
        .in_valid  (cl_tx_valid),
        .in_ready  (cl_tx_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_pop)
    );

    // Combinational decodes shared by the next-state logic and checks.
    assign adv      = !r.ovalid || link_tx_ready;
    assign req_eff  = (pause_req || r.ctrl[pfc_pkg::CTRL_REG_REQ])
                      && r.ctrl[pfc_pkg::CTRL_USER_EN];
    assign q_eff    = (r.quanta == 16'h0000) ? 16'h0001 : r.quanta;
    assign rx_done  = link_rx_valid && link_rx_last;
    assign is_pause = hdr16(r.hdr, 12) == pfc_pkg::ETYPE_CTRL
                      && (hdr16(r.hdr, 14) == pfc_pkg::OP_PAUSE
                      || (PFC_EN && hdr16(r.hdr, 14) == pfc_pkg::OP_PFC));
    assign da_match = {r.hdr[0], r.hdr[1], r.hdr[2], r.hdr[3], r.hdr[4], r.hdr[5]}
                      == r.fda;
    // A new client frame is held back while a received pause is timing out; a frame already started runs on.
    assign f_pop    = adv && f_valid && r.st != pfc_pkg::TX_PAUSE
                      && !(r.st == pfc_pkg::TX_IDLE
                      && (r.rxp != '0 || r.pend_xoff || r.pend_xon));

    assign prdata        = r.prdata;
    assign pready        = 1'b1;
    assign pslverr       = psel && penable && !addr_ok(paddr);
    assign link_tx_data  = r.odata;
    assign link_tx_valid = r.ovalid;
    assign link_tx_last  = r.olast;
    assign rx_pause_seen = r.seen;

    // ---------------------------------------------------------------
    // Next-state logic.
    // ---------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.seen = 1'b0;
        // Register writes take effect in the access phase.
        if (psel && penable && pwrite)
        begin
            case (paddr)
                pfc_pkg::ADDR_CTRL:    next_r.ctrl = pwdata[3:0];
                pfc_pkg::ADDR_QUANTA:  next_r.quanta = pwdata[15:0];
                pfc_pkg::ADDR_HOLDOFF: next_r.holdoff = pwdata[15:0];
                pfc_pkg::ADDR_FDA_LO:  next_r.fda[31:0] = pwdata;
                pfc_pkg::ADDR_FDA_HI:  next_r.fda[47:32] = pwdata[15:0];
                pfc_pkg::ADDR_SA_LO:   next_r.sa[31:0] = pwdata;
                pfc_pkg::ADDR_SA_HI:   next_r.sa[47:32] = pwdata[15:0];
                default:               next_r.ctrl = r.ctrl;
            endcase
        end
        // Read data is latched in the setup phase so it comes from a flop.
        if (psel && !penable)
        begin
            case (paddr)
                pfc_pkg::ADDR_CTRL:    next_r.prdata = {28'h0000000, r.ctrl};
                pfc_pkg::ADDR_QUANTA:  next_r.prdata = {16'h0000, r.quanta};
                pfc_pkg::ADDR_HOLDOFF: next_r.prdata = {16'h0000, r.holdoff};
                pfc_pkg::ADDR_FDA_LO:  next_r.prdata = r.fda[31:0];
                pfc_pkg::ADDR_FDA_HI:  next_r.prdata = {16'h0000, r.fda[47:32]};
                pfc_pkg::ADDR_SA_LO:   next_r.prdata = r.sa[31:0];
                pfc_pkg::ADDR_SA_HI:   next_r.prdata = {16'h0000, r.sa[47:32]};
                pfc_pkg::ADDR_STATUS:  next_r.prdata = {8'h00, r.rej, r.acc, 6'h00,
                                                        r.rxp != '0, r.req_q};
                default:               next_r.prdata = 32'h00000000;
            endcase
        end

        // Hold-off counts down after each XOFF and rearms a repeat.
        if (r.hold != 16'h0000)
        begin
            next_r.hold = r.hold - 16'h0001;
            if (r.hold == 16'h0001 && req_eff && r.req_q)
                next_r.pend_xoff = 1'b1;
        end
        if (r.rxp != '0)
            next_r.rxp = r.rxp - 22'h000001;

        // Transmit side: output stage advances when the link accepts.
        if (adv)
        begin
            next_r.ovalid = 1'b0;
            next_r.olast  = 1'b0;
            case (r.st)
                pfc_pkg::TX_IDLE:
                begin
                    if (r.pend_xoff || r.pend_xon)
                    begin
                        next_r.st    = pfc_pkg::TX_PAUSE;
                        next_r.pidx  = 6'h00;
                        next_r.pkind = r.pend_xoff;
                        next_r.pend_xoff = 1'b0;
                        next_r.pend_xon  = 1'b0;
                    end
                    else if (f_pop)
                    begin
                        next_r.odata  = f_data[7:0];
                        next_r.ovalid = 1'b1;
                        next_r.olast  = f_data[8];
                        next_r.st     = f_data[8] ? pfc_pkg::TX_IDLE : pfc_pkg::TX_CLIENT;
                    end
                end
                pfc_pkg::TX_CLIENT:
                begin
                    if (f_pop)
                    begin
                        next_r.odata  = f_data[7:0];
                        next_r.ovalid = 1'b1;
                        next_r.olast  = f_data[8];
                        if (f_data[8])
                            next_r.st = pfc_pkg::TX_IDLE;
                    end
                end
                pfc_pkg::TX_PAUSE:
                begin
                    // XON carries zero quanta; XOFF the configured value, or one when that is zero.
                    next_r.odata  = pause_byte(r.pidx, r.sa,
                                               r.pkind ? q_eff : 16'h0000);
                    next_r.ovalid = 1'b1;
                    next_r.pidx   = r.pidx + 6'h01;
                    if (r.pidx == pfc_pkg::FRAME_LAST)
                    begin
                        next_r.olast = 1'b1;
                        next_r.st    = pfc_pkg::TX_IDLE;
                        if (r.pkind)
                            next_r.hold = r.holdoff;
                    end
                end
                default: next_r.st = pfc_pkg::TX_IDLE;
            endcase
        end

        // A change of the request level queues the matching frame; a set
        // here wins over the clear done when a frame was started.
        next_r.req_q = req_eff;
        if (req_eff != r.req_q)
        begin
            next_r.pend_xoff = req_eff;
            next_r.pend_xon  = !req_eff;
            if (!req_eff)
                next_r.hold = 16'h0000;
        end

        // Receive side: capture the header and judge at end of frame.
        if (link_rx_valid)
        begin
            if (r.rx_idx <= pfc_pkg::RX_HDR_LAST)
            begin
                next_r.hdr[r.rx_idx] = link_rx_data;
                next_r.rx_idx = r.rx_idx + 5'h01;
            end
            if (link_rx_last)
            begin
                next_r.rx_idx = 5'h00;
                if (is_pause && r.ctrl[pfc_pkg::CTRL_RX_EN])
                begin
                    if (da_match)
                    begin
                        next_r.acc  = r.acc + 8'h01;
                        next_r.seen = 1'b1;
                        if (r.ctrl[pfc_pkg::CTRL_TXRX_EN])
                            next_r.rxp = {6'h00, PFC_EN && hdr16(r.hdr, 14)
                                == pfc_pkg::OP_PFC ? hdr16(r.hdr, 18)
                                : hdr16(r.hdr, 16)} << pfc_pkg::QUANTA_SHIFT;
                    end
                    else
                        next_r.rej = r.rej + 8'h01;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // State register.
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r         <= '0;
            r.ctrl    <= pfc_pkg::CTRL_RST;
            r.quanta  <= pfc_pkg::QUANTA_RST;
            r.holdoff <= pfc_pkg::HOLDOFF_RST;
            r.fda     <= pfc_pkg::FDA_RST;
            r.sa      <= pfc_pkg::SA_RST;
        end
        else
            r <= next_r;
    end

    // ---------------------------------------------------------------
    // Checks.
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_src;
        (adv && f_pop) |=> (link_tx_data == $past(f_data[7:0]));
    endproperty
    a_src: assert property (p_src) else $error("client byte altered");

    property p_level;
        (req_eff != r.req_q) |=> (r.pend_xoff == $past(req_eff)
            || (r.st == pfc_pkg::TX_PAUSE && r.pkind == $past(req_eff)));
    endproperty
    a_level: assert property (p_level) else $error("request change lost");

    property p_quanta;
        (adv && r.st == pfc_pkg::TX_PAUSE && r.pkind && r.pidx == 6'h10)
            |=> (link_tx_data == $past(q_eff[15:8]));
    endproperty
    a_quanta: assert property (p_quanta) else $error("quanta not from register");

    property p_regreq;
        ($rose(r.ctrl[pfc_pkg::CTRL_REG_REQ]) && !pause_req && r.ctrl[pfc_pkg::CTRL_USER_EN])
            |=> ##1 (r.pend_xoff || r.st == pfc_pkg::TX_PAUSE);
    endproperty
    a_regreq: assert property (p_regreq) else $error("register request ignored");

    property p_repeat;
        (r.hold == 16'h0001 && req_eff && r.req_q) |=> r.pend_xoff;
    endproperty
    a_repeat: assert property (p_repeat) else $error("XOFF not repeated");

    property p_filter;
        (rx_done && !da_match) |=> $stable(r.acc);
    endproperty
    a_filter: assert property (p_filter) else $error("unmatched pause accepted");

    property p_txrx;
        (r.rxp == '0 && !r.ctrl[pfc_pkg::CTRL_TXRX_EN]) |=> (r.rxp == '0);
    endproperty
    a_txrx: assert property (p_txrx) else $error("pause applied while off");

    property p_rxen;
        (rx_done && !r.ctrl[pfc_pkg::CTRL_RX_EN]) |=> ($stable(r.acc) && $stable(r.rej));
    endproperty
    a_rxen: assert property (p_rxen) else $error("pause processed while off");

    property p_xon;
        (adv && r.st == pfc_pkg::TX_PAUSE && !r.pkind && r.pidx == 6'h11)
            |=> (link_tx_data == 8'h00);
    endproperty
    a_xon: assert property (p_xon) else $error("XON quanta nonzero");
endmodule
